// [gpio_pkg.sv]
// Shared constants, types and helpers for the dual bank GPIO port
package gpio_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int PINS_PER_BANK = 8;
  localparam int NUM_PINS      = 16;
  localparam int ADDR_W        = 12;
  localparam int DATA_W        = 32;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_BANK_A   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_BANK_C   = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PIN_STAT = 12'h008;

  // ****************************************
  // Field positions inside a bank register
  // ****************************************
  localparam int FLD_MODE_LSB = 24;
  localparam int FLD_DIR_LSB  = 16;
  localparam int FLD_SF_LSB   = 8;
  localparam int FLD_DATA_LSB = 0;

  // Status register fields
  localparam int STAT_LEVEL_LSB   = 0;
  localparam int STAT_PRESS_BIT   = 16;
  localparam int STAT_RELEASE_BIT = 17;
  localparam int STAT_BUTTON_BIT  = 18;

  // Board wiring inside bank C
  localparam int LED_PIN    = 6;
  localparam int BUTTON_PIN = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0] RST_BANK_CFG = 32'h0000_0000;
  localparam logic [7:0]        RST_BYTE     = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  // Layout equals the register word: mode, direction, special function, data
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dir;
    logic [7:0] sf;
    logic [7:0] data;
  } bank_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } periph_drive_t;

  typedef enum logic [1:0] {
    ROLE_INPUT  = 2'b00,
    ROLE_OUTPUT = 2'b01,
    ROLE_PERIPH = 2'b10,
    ROLE_PARKED = 2'b11
  } pin_role_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic pin_role_t pin_role(input logic mode, input logic dir, input logic sf);
    if (mode) begin
      pin_role = ROLE_PERIPH;
    end else if (sf) begin
      pin_role = ROLE_PARKED;
    end else if (dir) begin
      pin_role = ROLE_OUTPUT;
    end else begin
      pin_role = ROLE_INPUT;
    end
  endfunction

  // Register word as read back: data field shows the live pin level
  function automatic logic [DATA_W-1:0] bank_readback(input bank_cfg_t cfg, input logic [7:0] level);
    bank_cfg_t r;
    r      = cfg;
    r.data = level;
    bank_readback = r;
  endfunction

endpackage

// [gpio_pin_bank.sv]
// Eight-pin bank: pin role decode and registered pin drive
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_bank #(
  parameter bit HAS_SF = 1'b1
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire gpio_pkg::bank_cfg_t   cfg,
  input  wire gpio_pkg::periph_drive_t periph,
  input  wire logic [7:0]            pin_in,
  output var  logic [7:0]            pin_out_ff,
  output var  logic [7:0]            pin_oe_ff,
  output var  logic [7:0]            periph_in_ff
);

  logic [7:0] nxt_pin_out;
  logic [7:0] nxt_pin_oe;

  // ****************************************
  // Role decode per pin
  // ****************************************
  always_comb begin
    nxt_pin_out = 8'h00;
    nxt_pin_oe  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      unique case (gpio_pkg::pin_role(cfg.mode[i], cfg.dir[i], HAS_SF & cfg.sf[i]))
        gpio_pkg::ROLE_INPUT: begin
          nxt_pin_oe[i] = 1'b0;
        end
        gpio_pkg::ROLE_OUTPUT: begin
          nxt_pin_out[i] = cfg.data[i];
          nxt_pin_oe[i]  = 1'b1;
        end
        gpio_pkg::ROLE_PERIPH: begin
          nxt_pin_out[i] = periph.out[i];
          nxt_pin_oe[i]  = periph.oe[i];
        end
        gpio_pkg::ROLE_PARKED: begin
          // Special function with no peripheral behind it: release the pin
          nxt_pin_oe[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out_ff <= gpio_pkg::RST_BYTE;
      pin_oe_ff  <= gpio_pkg::RST_BYTE;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end

  // Peripheral sees the pin only while the pin is handed to it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      periph_in_ff <= gpio_pkg::RST_BYTE;
    end else begin
      periph_in_ff <= pin_in & cfg.mode;
    end
  end

endmodule
`default_nettype wire

// [dual_bank_gpio_port.sv]
// Dual bank GPIO port with APB register access
//
// Behaviour
// - Sixteen pins, two registers, eight each
// - Mode, direction, special function, data per pin
// - Special function bit only in bank C
// - Data reads pin level, writes output level
// - Mode 0, dir 0, sf 0 is input
// - Mode 0, dir 1, sf 0 drives data
// - Button reads high released, low pressed
`timescale 1ns/1ns
`default_nettype none
module dual_bank_gpio_port (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // Pins: bank A in [7:0], bank C in [15:8]
  input  wire logic [15:0]            pin_in,
  output var  logic [15:0]            pin_out,
  output var  logic [15:0]            pin_oe,
  // Alternate function peripherals
  input  wire gpio_pkg::periph_drive_t periph_a,
  input  wire gpio_pkg::periph_drive_t periph_c,
  output var  logic [15:0]            periph_in,
  // Board indicators
  output var  logic                   led_lit,
  output var  logic                   button_pressed
);

  // ****************************************
  // Register state
  // ****************************************
  gpio_pkg::bank_cfg_t bank_a_ff;
  gpio_pkg::bank_cfg_t bank_c_ff;
  logic                press_seen_ff;
  logic                release_seen_ff;
  logic                button_prev_ff;
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;
  logic                led_lit_ff;
  logic                button_pressed_ff;

  logic                setup_phase;
  logic                wr_commit;
  logic                hit_a;
  logic                hit_c;
  logic                hit_stat;
  logic                mapped;
  logic [31:0]         nxt_prdata;
  logic [31:0]         stat_word;
  logic                button_level;
  logic                press_evt;
  logic                release_evt;
  logic [7:0]          bank_a_out;
  logic [7:0]          bank_a_oe;
  logic [7:0]          bank_c_out;
  logic [7:0]          bank_c_oe;
  logic [7:0]          bank_a_pin_in;
  logic [7:0]          bank_c_pin_in;
  logic                access_done;
  logic                clr_press;
  logic                clr_release;
  logic                led_is_output;

  // ****************************************
  // Address decode
  // ****************************************
  assign hit_a       = (paddr == gpio_pkg::OFF_BANK_A);
  assign hit_c       = (paddr == gpio_pkg::OFF_BANK_C);
  assign hit_stat    = (paddr == gpio_pkg::OFF_PIN_STAT);
  assign mapped      = hit_a | hit_c | hit_stat;
  assign setup_phase = psel & ~penable;
  // Unaligned or unlisted addresses miss every register and answer with pslverr
  // Writes land only at the edge where the master sees pready
  assign access_done = psel & penable & pready_ff;
  assign wr_commit   = access_done & pwrite;

  assign bank_a_pin_in = pin_in[7:0];
  assign bank_c_pin_in = pin_in[15:8];

  // ****************************************
  // Button sensing
  // ****************************************
  // Low level means pressed; events are edges of the sampled pin
  assign button_level = bank_c_pin_in[gpio_pkg::BUTTON_PIN];
  assign press_evt    = button_prev_ff & ~button_level;
  assign release_evt  = ~button_prev_ff & button_level;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      button_prev_ff <= 1'b1;
    end else begin
      button_prev_ff <= button_level;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      button_pressed_ff <= 1'b0;
    end else begin
      button_pressed_ff <= ~button_level;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[gpio_pkg::STAT_LEVEL_LSB +: 16] = pin_in;
    stat_word[gpio_pkg::STAT_PRESS_BIT]       = press_seen_ff;
    stat_word[gpio_pkg::STAT_RELEASE_BIT]     = release_seen_ff;
    stat_word[gpio_pkg::STAT_BUTTON_BIT]      = ~button_level;
  end

  // ****************************************
  // Bank configuration registers
  // ****************************************
  // Whole-word writes only; merging one pin is software's job
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_a_ff <= gpio_pkg::RST_BANK_CFG;
    end else if (wr_commit && hit_a) begin
      bank_a_ff    <= pwdata;
      bank_a_ff.sf <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_c_ff <= gpio_pkg::RST_BANK_CFG;
    end else if (wr_commit && hit_c) begin
      bank_c_ff <= pwdata;
    end
  end

  // ****************************************
  // Sticky button events, write one to clear
  // ****************************************
  // A new edge in the clearing cycle keeps the flag set
  assign clr_press   = wr_commit & hit_stat & pwdata[gpio_pkg::STAT_PRESS_BIT];
  assign clr_release = wr_commit & hit_stat & pwdata[gpio_pkg::STAT_RELEASE_BIT];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      press_seen_ff <= 1'b0;
    end else if (press_evt) begin
      press_seen_ff <= 1'b1;
    end else if (clr_press) begin
      press_seen_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      release_seen_ff <= 1'b0;
    end else if (release_evt) begin
      release_seen_ff <= 1'b1;
    end else if (clr_release) begin
      release_seen_ff <= 1'b0;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (hit_a) begin
      nxt_prdata = gpio_pkg::bank_readback(bank_a_ff, bank_a_pin_in);
    end else if (hit_c) begin
      nxt_prdata = gpio_pkg::bank_readback(bank_c_ff, bank_c_pin_in);
    end else if (hit_stat) begin
      nxt_prdata = stat_word;
    end
  end

  // One access cycle, no wait states
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup_phase;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup_phase & ~mapped;
    end
  end

  // Pin level is captured in the setup cycle
  // Read data drops to zero one cycle after psel falls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end else if (!psel) begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Pin banks
  // ****************************************
  gpio_pin_bank #(
    .HAS_SF (1'b0)
  ) u_bank_a (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .cfg          (bank_a_ff),
    .periph       (periph_a),
    .pin_in       (bank_a_pin_in),
    .pin_out_ff   (bank_a_out),
    .pin_oe_ff    (bank_a_oe),
    .periph_in_ff (periph_in[7:0])
  );

  gpio_pin_bank #(
    .HAS_SF (1'b1)
  ) u_bank_c (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .cfg          (bank_c_ff),
    .periph       (periph_c),
    .pin_in       (bank_c_pin_in),
    .pin_out_ff   (bank_c_out),
    .pin_oe_ff    (bank_c_oe),
    .periph_in_ff (periph_in[15:8])
  );

  // ****************************************
  // LED indicator
  // ****************************************
  // Same role decode as the pin bank; the lamp follows the pin except while the pin is handed to the peripheral
  assign led_is_output = (gpio_pkg::pin_role(bank_c_ff.mode[gpio_pkg::LED_PIN],
                                             bank_c_ff.dir[gpio_pkg::LED_PIN],
                                             bank_c_ff.sf[gpio_pkg::LED_PIN]) == gpio_pkg::ROLE_OUTPUT);

  // Lit only while the pin is driven high, as the active-high lamp sees it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      led_lit_ff <= 1'b0;
    end else begin
      led_lit_ff <= led_is_output & bank_c_ff.data[gpio_pkg::LED_PIN];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pin_out        = {bank_c_out, bank_a_out};
  assign pin_oe         = {bank_c_oe, bank_a_oe};
  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign led_lit        = led_lit_ff;
  assign button_pressed = button_pressed_ff;

endmodule
`default_nettype wire

// [gpio_port_checker.sv]
// Concurrent checks on the dual bank GPIO port pins and APB side
`timescale 1ns/1ns
`default_nettype none
module gpio_port_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic        led_lit,
  input wire logic        button_pressed
);
  // ****************************************
  // Bus phases
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ready;
    pready;
  endsequence
  wire logic done = psel && penable && pready;
  wire logic wr_done = done && pwrite;

  a_ready_next: assert property (s_setup |=> s_ready) else $error("no ready after setup");
  a_ready_pulse: assert property (s_ready |=> !pready) else $error("ready held too long");
  a_idle_rdata: assert property (!psel |=> prdata == 32'h0000_0000) else $error("read data while idle");
  a_err_unmapped: assert property (done && paddr > gpio_pkg::OFF_PIN_STAT |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access accepted");
  a_ok_mapped: assert property (done && paddr[1:0] == 2'h0 && paddr <= gpio_pkg::OFF_PIN_STAT |-> !pslverr)
    else $error("mapped access refused");
  // The bench moves periph drive only while no pin is in peripheral mode, so only writes move the enables
  a_oe_by_write: assert property ($changed(pin_oe) |-> $past(wr_done, 1) || $past(wr_done, 2))
    else $error("output enable moved without a write");
  a_led_pin: assert property ($rose(led_lit) |-> pin_oe[14] && pin_out[14]) else $error("lamp without pin drive");
  a_button_lag: assert property (!rst |=> button_pressed == !$past(pin_in[13]))
    else $error("button state wrong");
endmodule
`default_nettype wire

// [board_model.sv]
// Board side of the port: red lamp and pushbutton with pull-up
`timescale 1ns/1ns
`default_nettype none
module board_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic        button_down,
  input  wire logic [15:0] float_lvl,
  output var  logic [15:0] pin_in,
  output var  logic        led_on
);
  // Undriven pins other than the button pin show a fixed pattern, not a friendly zero
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & float_lvl);
    if (!pin_oe[13]) begin
      pin_in[13] = !button_down;
    end
  end
  assign led_on = pin_oe[14] & pin_out[14];
endmodule
`default_nettype wire

// [test_dual_bank_gpio_port.sv]
// Self-checking bench for the dual bank GPIO port
`timescale 1ns/1ns
`default_nettype none
module test_dual_bank_gpio_port;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, led_lit, button_pressed, button_down, err, led_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pin_in, pin_out, pin_oe, periph_in;
  gpio_pkg::periph_drive_t periph_c;
  int error_cnt, n_checks, cyc;
  localparam logic [11:0] A = gpio_pkg::OFF_BANK_A;
  localparam logic [11:0] C = gpio_pkg::OFF_BANK_C;
  localparam logic [11:0] S = gpio_pkg::OFF_PIN_STAT;

  dual_bank_gpio_port uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_a(gpio_pkg::periph_drive_t'(16'h0000)), .periph_c(periph_c),
    .periph_in(periph_in), .led_lit(led_lit), .button_pressed(button_pressed));
  board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .button_down(button_down), .float_lvl(16'h3c96),
    .pin_in(pin_in), .led_on(led_on));

  // ****************************************
  // Clock, timeout, verdict
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
    chk_reg({16'h0000, g}, {16'h0000, e});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {psel, penable, pwrite, button_down, error_cnt, n_checks} = '0;
    {paddr, pwdata} = '0;
    periph_c = gpio_pkg::periph_drive_t'(16'h0000);
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(A, 32'h0000_0096);
    rdchk(C, 32'h0000_003c);
    apb(1'b0, C, 32'h0000_0000);
    apb(1'b1, C, rd | 32'h0040_0040);
    settle();
    chk_pin(pin_oe, 16'h4000);
    chk_pin({15'h0000, led_on & led_lit}, 16'h0001);
    rdchk(C, 32'h0040_007c);
    button_down <= 1'b1;
    settle();
    chk_pin({15'h0000, button_pressed}, 16'h0001);
    rdchk(C, 32'h0040_005c);
    rdchk(S, 32'h0005_5c96);
    apb(1'b1, S, 32'h0001_0000);
    rdchk(S, 32'h0004_5c96);
    button_down <= 1'b0;
    settle();
    rdchk(S, 32'h0002_7c96);
    apb(1'b1, C, 32'h0040_4040);
    settle();
    chk_pin({pin_oe[15:1], led_lit}, 16'h0000);
    apb(1'b1, A, 32'h0000_ff00);
    rdchk(A, 32'h0000_0096);
    apb(1'b1, A, 32'h00ff_00a5);
    apb(1'b1, C, 32'h00ff_005a);
    settle();
    chk_pin(pin_oe, 16'hffff);
    chk_pin(pin_out, 16'h5aa5);
    rdchk(A, 32'h00ff_00a5);
    periph_c <= gpio_pkg::periph_drive_t'(16'h0101);
    apb(1'b1, C, 32'h0100_0000);
    settle();
    chk_pin(pin_oe, 16'h01ff);
    chk_pin(periph_in, 16'h0100);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000);
    chk_pin({15'h0000, err}, 16'h0001);
    apb(1'b1, C, 32'h0040_0040);
    settle();
    chk_pin({15'h0000, led_lit & led_on}, 16'h0001);
    report_and_stop();
  end
endmodule

bind dual_bank_gpio_port gpio_port_checker chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .led_lit(led_lit), .button_pressed(button_pressed));
`default_nettype wire
